// ==== event_channel_router.sv ====
`timescale 1ns/1ps

module event_channel_router #(
   parameter int NUM_GENERATORS = 128,
   parameter int NUM_USERS      = 4,
   parameter logic [3:0] CHANNEL_ID = 4'h0
) (
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   // Register port
   input  wire logic [7:0]                  regAddr,
   input  wire logic [31:0]                 regWdata,
   input  wire logic                        regWrite,
   input  wire logic                        regRead,
   output logic [31:0]                      regRdata,
   // Generators
   input  wire logic [NUM_GENERATORS-1:0]   genEvents,
   // Users
   input  wire logic [NUM_USERS-1:0]        userAttached,
   input  wire logic [NUM_USERS-1:0]        userReady,
   input  wire logic [NUM_USERS-1:0]        userAck,
   output logic                             userEvent,
   // Clock request and interrupt
   output logic                             clockRequest,
   output logic                             irq
);

   typedef struct packed {
      logic [event_router_pkg::GEN_SEL_W-1:0] generatorSelect;
      event_router_pkg::path_t                pathSel;
      event_router_pkg::edge_t                edgeSelect;
      logic                                   clockRequestAlways;
      logic                                   syncStage1;
      logic                                   syncStage2;
      logic                                   swLevel;
      logic                                   userEvent;
      logic [NUM_USERS-1:0]                   ackPending;
      logic                                   chanBusyFlag;
      logic                                   usersReadyFlag;
      logic [3:0]                             holdCount;
      logic                                   clockRequest;
      logic [1:0]                             irqStatus;
      logic [1:0]                             irqMask;
      logic                                   irq;
      logic [31:0]                            rdata;
   } router_state_t;

   router_state_t stateReg;
   router_state_t stateNext;

   logic          selLevel;
   logic          edgePulse;
   logic          eventPulse;
   logic          readyAll;
   logic          swTrigger;
   logic [NUM_USERS-1:0] ackMask;

   // Generator select; index 0 means unconnected
   always_comb begin
      selLevel = 1'b0;
      if ((stateReg.generatorSelect != '0) &&
          (int'(stateReg.generatorSelect) < NUM_GENERATORS)) begin
         selLevel = genEvents[stateReg.generatorSelect];
      end
   end

   // One write with trigger and this channel number
   assign swTrigger = regWrite && (regAddr == event_router_pkg::SOFT_EVENT_OFS) &&
                      regWdata[event_router_pkg::SW_TRIG_BIT] &&
                      (regWdata[event_router_pkg::SW_CHAN_LSB +: event_router_pkg::SW_CHAN_W] ==
                       CHANNEL_ID);

   // Sync path uses the raw level; resync path uses the double-flopped one
   edge_detect edgeUnit (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .levelIn    ((stateReg.pathSel == event_router_pkg::PATH_RESYNC) ?
                   (stateReg.syncStage2 | stateReg.swLevel) :
                   (selLevel | stateReg.swLevel)),
      .edgeSelect (stateReg.edgeSelect),
      .pulseOut   (edgePulse)
   );

   // Asynchronous path passes the level straight to users, registered
   assign eventPulse = (stateReg.pathSel == event_router_pkg::PATH_ASYNC) ? selLevel : edgePulse;

   // Only attached users count toward ready and ack
   assign readyAll = &(userReady | ~userAttached);
   assign ackMask  = userAck & userAttached;

   always_comb begin
      stateNext = stateReg;
      stateNext.rdata = 32'h0000_0000;

      // Two-stage synchronizer; stage 1 read only by stage 2
      stateNext.syncStage1 = selLevel;
      stateNext.syncStage2 = stateReg.syncStage1;

      // Software event: a one-cycle high level that the rising detector sees
      stateNext.swLevel = swTrigger;

      // Event to users
      stateNext.userEvent = eventPulse;

      // Busy tracking: new event loads pending users, acks retire them
      if (eventPulse) begin
         stateNext.ackPending = userAttached;
      end else begin
         stateNext.ackPending = stateReg.ackPending & ~ackMask;
      end
      stateNext.chanBusyFlag   = |stateNext.ackPending;
      stateNext.usersReadyFlag = readyAll;

      // Clock request: always-on, or held briefly around activity
      if (eventPulse || swTrigger || stateReg.chanBusyFlag ||
          (selLevel != stateReg.syncStage2)) begin
         stateNext.holdCount = event_router_pkg::CLK_HOLD_CYCLES;
      end else if (stateReg.holdCount != 4'h0) begin
         stateNext.holdCount = stateReg.holdCount - 4'h1;
      end
      stateNext.clockRequest = stateReg.clockRequestAlways ||
                               (stateNext.holdCount != 4'h0);

      // Register writes; the path/edge fields are software's to set legally
      if (regWrite) begin
         if (regAddr == event_router_pkg::CHANNEL_CFG_OFS) begin
            stateNext.generatorSelect = regWdata[event_router_pkg::GEN_SEL_LSB +:
                                                 event_router_pkg::GEN_SEL_W];
            stateNext.pathSel    = event_router_pkg::path_t'(regWdata[event_router_pkg::PATH_LSB +: 2]);
            stateNext.edgeSelect = event_router_pkg::edge_t'(regWdata[event_router_pkg::EDGE_LSB +: 2]);
         end else if (regAddr == event_router_pkg::CONTROL_OFS) begin
            stateNext.clockRequestAlways = regWdata[event_router_pkg::CLKREQ_BIT];
         end else if (regAddr == event_router_pkg::IRQ_STATUS_OFS) begin
            stateNext.irqStatus = stateReg.irqStatus & ~regWdata[1:0];
         end else if (regAddr == event_router_pkg::IRQ_MASK_OFS) begin
            stateNext.irqMask = regWdata[1:0];
         end
      end

      // Interrupt events only on resync path; set wins over clear
      if (stateReg.pathSel == event_router_pkg::PATH_RESYNC) begin
         if (eventPulse) begin
            stateNext.irqStatus[event_router_pkg::IRQ_EVT_BIT] = 1'b1;
         end
         if (readyAll && !stateReg.usersReadyFlag) begin
            stateNext.irqStatus[event_router_pkg::IRQ_RDY_BIT] = 1'b1;
         end
      end
      stateNext.irq = |(stateNext.irqStatus & stateNext.irqMask);

      // Read decode; data valid the cycle after the strobe
      if (regRead) begin
         if (regAddr == event_router_pkg::CHANNEL_CFG_OFS) begin
            stateNext.rdata[event_router_pkg::GEN_SEL_LSB +: event_router_pkg::GEN_SEL_W] =
               stateReg.generatorSelect;
            stateNext.rdata[event_router_pkg::PATH_LSB +: 2] = stateReg.pathSel;
            stateNext.rdata[event_router_pkg::EDGE_LSB +: 2] = stateReg.edgeSelect;
         end else if (regAddr == event_router_pkg::CONTROL_OFS) begin
            stateNext.rdata[event_router_pkg::CLKREQ_BIT] = stateReg.clockRequestAlways;
         end else if (regAddr == event_router_pkg::CHANNEL_STATE_OFS) begin
            stateNext.rdata[event_router_pkg::BUSY_BIT]  = stateReg.chanBusyFlag;
            stateNext.rdata[event_router_pkg::READY_BIT] = stateReg.usersReadyFlag;
         end else if (regAddr == event_router_pkg::IRQ_STATUS_OFS) begin
            stateNext.rdata[1:0] = stateReg.irqStatus;
         end else if (regAddr == event_router_pkg::IRQ_MASK_OFS) begin
            stateNext.rdata[1:0] = stateReg.irqMask;
         end
      end
   end

   // Single state register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stateReg <= '0;
      end else begin
         stateReg <= stateNext;
      end
   end

   assign regRdata     = stateReg.rdata;
   assign userEvent    = stateReg.userEvent;
   assign clockRequest = stateReg.clockRequest;
   assign irq          = stateReg.irq;

endmodule

// ==== event_router_pkg.sv ====
package event_router_pkg;

   // Register offsets (byte addresses, word registers)
   localparam logic [7:0] CHANNEL_CFG_OFS    = 8'h00;
   localparam logic [7:0] CONTROL_OFS        = 8'h04;
   localparam logic [7:0] SOFT_EVENT_OFS     = 8'h08;
   localparam logic [7:0] CHANNEL_STATE_OFS  = 8'h0C;
   localparam logic [7:0] IRQ_STATUS_OFS     = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFS       = 8'h14;

   // Channel configuration field positions
   localparam int GEN_SEL_LSB  = 0;
   localparam int GEN_SEL_W    = 7;
   localparam int PATH_LSB     = 8;
   localparam int EDGE_LSB     = 10;
   // Control field positions
   localparam int CLKREQ_BIT   = 0;
   // Software event register fields
   localparam int SW_CHAN_LSB  = 0;
   localparam int SW_CHAN_W    = 4;
   localparam int SW_TRIG_BIT  = 8;
   // Channel state / irq bits
   localparam int BUSY_BIT     = 0;
   localparam int READY_BIT    = 1;
   localparam int IRQ_EVT_BIT  = 0;
   localparam int IRQ_RDY_BIT  = 1;

   // Reset values
   localparam logic [31:0] CHANNEL_CFG_RST = 32'h0000_0000;
   localparam logic        CLKREQ_RST      = 1'b0;
   localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;

   // Path choices
   typedef enum logic [1:0] {
      PATH_SYNC    = 2'b00,
      PATH_RESYNC  = 2'b01,
      PATH_ASYNC   = 2'b10
   } path_t;

   // Edge detection choices
   typedef enum logic [1:0] {
      EDGE_NONE    = 2'b00,
      EDGE_RISE    = 2'b01,
      EDGE_FALL    = 2'b10,
      EDGE_BOTH    = 2'b11
   } edge_t;

   // Cycles the clock request stays up after last activity
   localparam logic [3:0] CLK_HOLD_CYCLES = 4'h4;

endpackage

// ==== edge_detect.sv ====
`timescale 1ns/1ps

module edge_detect (
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_n,
   // Level in, mode
   input  wire logic                        levelIn,
   input  wire event_router_pkg::edge_t     edgeSelect,
   // Pulse out
   output logic                             pulseOut
);

   typedef struct packed {
      logic lastLevel;
      logic pulse;
   } edge_state_t;

   edge_state_t stateReg;
   edge_state_t stateNext;

   // Compare with level one cycle earlier
   always_comb begin
      stateNext           = stateReg;
      stateNext.lastLevel = levelIn;
      case (edgeSelect)
         event_router_pkg::EDGE_RISE: stateNext.pulse = levelIn & ~stateReg.lastLevel;
         event_router_pkg::EDGE_FALL: stateNext.pulse = ~levelIn & stateReg.lastLevel;
         event_router_pkg::EDGE_BOTH: stateNext.pulse = levelIn ^ stateReg.lastLevel;
         default:                     stateNext.pulse = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stateReg <= '0;
      end else begin
         stateReg <= stateNext;
      end
   end

   assign pulseOut = stateReg.pulse;

endmodule

// ==== event_channel_router_props.sv ====
`timescale 1ns/1ps

module event_channel_router_props #(
   parameter int         NUM_GENERATORS = 128,
   parameter logic [3:0] CHANNEL_ID     = 4'h0
) (
   // Clock, reset and register port
   input wire logic                      mclk,
   input wire logic                      rst_n,
   input wire logic [7:0]                regAddr,
   input wire logic [31:0]               regWdata,
   input wire logic                      regWrite,
   input wire logic                      regRead,
   input wire logic [31:0]               regRdata,
   // Channel side
   input wire logic [NUM_GENERATORS-1:0] genEvents,
   input wire logic                      userEvent,
   input wire logic                      clockRequest,
   input wire logic                      irq
);
   logic [11:0] cfgReg;
   logic        alwaysReg;
   logic [3:0]  quietReg;
   logic        selLevel;

   // Selected generator level as the channel should see it; select 0 is unconnected
   assign selLevel = (cfgReg[6:0] != 7'h00) && genEvents[cfgReg[6:0]];

   // Shadow of configuration writes; the checker cannot see internals
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfgReg    <= 12'h000;
         alwaysReg <= 1'b0;
         quietReg  <= 4'h0;
      end else begin
         if (regWrite && regAddr == event_router_pkg::CHANNEL_CFG_OFS) cfgReg <= regWdata[11:0];
         if (regWrite && regAddr == event_router_pkg::CONTROL_OFS) alwaysReg <= regWdata[0];
         if (cfgReg[11:10] != 2'h0 || cfgReg[9:8] == 2'h2) quietReg <= 4'h0;
         else if (quietReg != 4'hF) quietReg <= quietReg + 4'h1;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0000_0000)
      else $error("read data not zero outside a read answer");
   chk_unmapped_read: assert property (regRead && regAddr == 8'h20 |=> regRdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_single_pulse: assert property (userEvent && cfgReg[9:8] != 2'h2 && cfgReg[11:10] != 2'h3 |=> !userEvent)
      else $error("event pulse longer than one cycle");
   chk_no_edge: assert property (quietReg >= 4'h6 |-> !userEvent)
      else $error("event with edge detection off");
   chk_sync_delay: assert property (cfgReg[11:8] == 4'h4 && $rose(selLevel) |-> ##[2:3] userEvent)
      else $error("sync path rise gave no event");
   chk_resync_delay: assert property (cfgReg[11:8] == 4'h5 && $rose(selLevel) |-> ##[4:5] userEvent)
      else $error("resync path rise gave no event");
   chk_mask_off: assert property (regWrite && regAddr == event_router_pkg::IRQ_MASK_OFS && regWdata[1:0] == 2'h0
      ##1 !(regWrite && regAddr == event_router_pkg::IRQ_MASK_OFS) |=> !irq)
      else $error("interrupt high with all masked");
   chk_clock_on: assert property (alwaysReg && $past(alwaysReg) |-> clockRequest)
      else $error("clock request low in always-on mode");
   chk_soft_event: assert property (regWrite && regAddr == event_router_pkg::SOFT_EVENT_OFS && regWdata[8]
      && regWdata[3:0] == CHANNEL_ID && cfgReg[11:10] == 2'h1 && cfgReg[9:8] != 2'h2 |-> ##[3:4] userEvent)
      else $error("software event did not reach users");
endmodule

// ==== event_user_model.sv ====
`timescale 1ns/1ps

module event_user_model #(
   parameter int NUM_USERS = 4
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   // Channel side
   input  wire logic                 userEvent,
   input  wire logic [3:0]           ackDelay,
   output logic [NUM_USERS-1:0]      userReady,
   output logic [NUM_USERS-1:0]      userAck
);
   int cnt [NUM_USERS];

   // Each user drops ready, works ackDelay+index+1 cycles, then acks once
   always_ff @(posedge mclk or negedge rst_n) begin
      for (int i = 0; i < NUM_USERS; i++) begin
         if (!rst_n) begin
            cnt[i]       <= 0;
            userReady[i] <= 1'b1;
            userAck[i]   <= 1'b0;
         end else if (userEvent) begin
            cnt[i]       <= int'(ackDelay) + i + 1;
            userReady[i] <= 1'b0;
            userAck[i]   <= 1'b0;
         end else begin
            userAck[i]   <= (cnt[i] == 1);
            userReady[i] <= userReady[i] | (cnt[i] == 1);
            if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
         end
      end
   end
endmodule

// ==== event_channel_router_tb.sv ====
`timescale 1ns/1ps

module event_channel_router_tb;
   logic         mclk = 1'b0;
   logic         rst_n;
   logic [7:0]   regAddr;
   logic [31:0]  regWdata;
   logic         regWrite;
   logic         regRead;
   logic [31:0]  regRdata;
   logic [127:0] genEvents;
   logic [3:0]   userAttached;
   logic [3:0]   userReady;
   logic [3:0]   userAck;
   logic         userEvent;
   logic         clockRequest;
   logic         irq;
   logic [31:0]  rd;
   int           badCount;
   int           cmpCount;
   int           evCount;

   event_channel_router #(.CHANNEL_ID(4'h2)) dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .genEvents(genEvents),
      .userAttached(userAttached), .userReady(userReady), .userAck(userAck), .userEvent(userEvent),
      .clockRequest(clockRequest), .irq(irq));
   event_user_model users (.mclk(mclk), .rst_n(rst_n), .userEvent(userEvent), .ackDelay(4'h2),
      .userReady(userReady), .userAck(userAck));

   always #20 mclk = ~mclk;
   // Count every event pulse seen by the users
   always @(posedge mclk) if (userEvent === 1'b1) evCount++;

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic checkWord(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic checkBit(input string nm, input logic exp, input logic got);
      checkWord(nm, {31'h0, exp}, {31'h0, got});
   endtask
   task automatic regWr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   // Read data is looked at only in the answer cycle
   task automatic regRd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   // All generators toggle together, so select 0 is covered too
   task automatic run(input logic [31:0] cfg, input int n);
      int base;
      regWr(event_router_pkg::CHANNEL_CFG_OFS, cfg);
      #1 base = evCount;
      @(posedge mclk);
      genEvents <= '1;
      cyc(4);
      genEvents <= '0;
      cyc(12);
      #1 checkWord("event count", 32'(n), 32'(evCount - base));
   endtask
   task automatic tallyAndFinish();
      $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      cyc(5000);
      badCount++;
      tallyAndFinish();
   end

   initial begin
      int base;
      {regAddr, regWdata, regWrite, regRead, genEvents} = '0;
      userAttached = 4'h5;
      rst_n = 1'b0;
      cyc(12);
      rst_n <= 1'b1;
      regRd(event_router_pkg::CHANNEL_CFG_OFS, rd);
      checkWord("cfg reset", event_router_pkg::CHANNEL_CFG_RST, rd);
      regRd(8'h20, rd);
      checkWord("unmapped", 32'h0000_0000, rd);
      regRd(event_router_pkg::CHANNEL_STATE_OFS, rd);
      checkWord("state idle", 32'h0000_0002, rd);
      checkBit("clock idle", 1'b0, clockRequest);
      run(32'h0000_0400, 0);
      run(32'h0000_0005, 0);
      run(32'h0000_0405, 1);
      run(32'h0000_0805, 1);
      run(32'h0000_0C05, 2);
      run(32'h0000_0505, 1);
      // Busy until both attached users acknowledge
      regWr(event_router_pkg::CHANNEL_CFG_OFS, 32'h0000_0405);
      genEvents <= '1;
      cyc(4);
      regRd(event_router_pkg::CHANNEL_STATE_OFS, rd);
      checkWord("state busy", 32'h0000_0001, rd);
      checkBit("clock on demand", 1'b1, clockRequest);
      genEvents <= '0;
      cyc(10);
      regRd(event_router_pkg::CHANNEL_STATE_OFS, rd);
      checkWord("state done", 32'h0000_0002, rd);
      cyc(10);
      #1 checkBit("clock released", 1'b0, clockRequest);
      // Interrupt on the resync path: raise, mask, clear; earlier runs left flags set
      regWr(event_router_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
      regWr(event_router_pkg::IRQ_MASK_OFS, 32'h0000_0001);
      cyc(2);
      #1 checkBit("irq before event", 1'b0, irq);
      regWr(event_router_pkg::CHANNEL_CFG_OFS, 32'h0000_0505);
      genEvents <= '1;
      // Look after the edge so the value launched there has settled
      for (int i = 0; i < 20 && irq !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      checkBit("irq raised", 1'b1, irq);
      if (irq !== 1'b1) tallyAndFinish();
      genEvents <= '0;
      regRd(event_router_pkg::IRQ_STATUS_OFS, rd);
      checkWord("status event", 32'h0000_0001, rd & 32'h0000_0001);
      regWr(event_router_pkg::IRQ_MASK_OFS, 32'h0000_0000);
      cyc(12);
      #1 checkBit("irq masked", 1'b0, irq);
      regRd(event_router_pkg::IRQ_STATUS_OFS, rd);
      checkWord("status both", 32'h0000_0003, rd);
      regWr(event_router_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
      regWr(event_router_pkg::IRQ_MASK_OFS, 32'h0000_0003);
      cyc(2);
      #1 checkBit("irq cleared", 1'b0, irq);
      // Software events with the clock forced on
      regWr(event_router_pkg::CONTROL_OFS, 32'h0000_0001);
      cyc(2);
      #1 checkBit("clock always", 1'b1, clockRequest);
      regWr(event_router_pkg::CHANNEL_CFG_OFS, 32'h0000_0400);
      #1 base = evCount;
      regWr(event_router_pkg::SOFT_EVENT_OFS, 32'h0000_0102);
      regWr(event_router_pkg::SOFT_EVENT_OFS, 32'h0000_0101);
      regWr(event_router_pkg::SOFT_EVENT_OFS, 32'h0000_0002);
      cyc(8);
      #1 checkWord("soft events", 32'h0000_0001, 32'(evCount - base));
      tallyAndFinish();
   end
endmodule

bind event_channel_router event_channel_router_props #(.NUM_GENERATORS(NUM_GENERATORS), .CHANNEL_ID(CHANNEL_ID))
   props (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
   .regRead(regRead), .regRdata(regRdata), .genEvents(genEvents), .userEvent(userEvent),
   .clockRequest(clockRequest), .irq(irq));
